/* File: rtl/asp_pkg.sv */
// Package with pin timing and speed-grade constants for the static memory port controller
package asp_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int ASP_ADDR_W = 19;
	localparam int ASP_DATA_W = 8;
	localparam int ASP_WORDS  = 524288;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int ASP_CLK_PERIOD_NS = 10;

	// ------------------------------------------------------------
	// Speed grades 0, 1, 2 (fastest first), times in ns
	// ------------------------------------------------------------
	localparam int ASP_GRADES = 3;
	localparam int ASP_READ_CYCLE_MIN_NS [ASP_GRADES]        = '{17, 20, 25};
	localparam int ASP_ADDRESS_TO_DATA_MAX_NS [ASP_GRADES]   = '{17, 20, 25};
	localparam int ASP_SELECT_TO_DATA_MAX_NS [ASP_GRADES]    = '{17, 20, 25};
	localparam int ASP_ENABLE_TO_DATA_MAX_NS [ASP_GRADES]    = '{8, 10, 12};
	localparam int ASP_WRITE_CYCLE_MIN_NS [ASP_GRADES]       = '{17, 20, 25};
	localparam int ASP_SELECT_TO_WRITE_END_MIN_NS [ASP_GRADES] = '{12, 13, 15};
	localparam int ASP_ADDRESS_TO_WRITE_END_MIN_NS [ASP_GRADES] = '{12, 13, 15};
	localparam int ASP_WRITE_PULSE_MIN_NS [ASP_GRADES]       = '{12, 13, 15};
	localparam int ASP_WRITE_PULSE_OUTPUTS_ON_MIN_NS [ASP_GRADES] = '{17, 20, 25};
	localparam int ASP_DATA_SETUP_TO_WRITE_END_NS [ASP_GRADES] = '{8, 9, 10};
	localparam int ASP_ADDRESS_SETUP_MIN_NS   = 0;
	localparam int ASP_WRITE_RECOVERY_MIN_NS  = 0;
	localparam int ASP_DATA_HOLD_AFTER_WRITE_NS = 0;

	// Least times round up to whole cycles, never below one
	function automatic int asp_cycles_up(input int ns);
		int c;
		c = (ns + ASP_CLK_PERIOD_NS - 1) / ASP_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Counter width for the longest phase
	localparam int ASP_CNT_W = 4;

	// ------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ASP_IDLE  = 3'b000,
		ASP_RSEL  = 3'b001,
		ASP_RDONE = 3'b010,
		ASP_WSET  = 3'b011,
		ASP_WPULSE = 3'b100,
		ASP_WEND  = 3'b101
	} asp_state_e;

endpackage

/* File: rtl/asp_count.sv */
// Down counter that times the read select and write pulse phases of a memory cycle
`timescale 1ns/1ns
module asp_count
	import asp_pkg::*;
#(
	parameter int CNT_W = ASP_CNT_W
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Control
	input  wire logic             load_in,
	input  wire logic [CNT_W-1:0] value_in,
	// Status
	output logic                  done_out
);

	logic [CNT_W-1:0] cnt_q;

	// The decrement constant needs at least two bits
	initial begin
		if (CNT_W < 2) begin
			$error("asp_count: counter must be at least two bits wide");
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= '0;
		end else if (load_in) begin
			cnt_q <= value_in;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Done while the count is zero and no load is pending, so a phase of N cycles loads N-1
	assign done_out = (cnt_q == '0) && !load_in;

endmodule

/* File: rtl/asp_ctrl.sv */
// Clocked controller that drives a 512K x 8 asynchronous static memory through its pins
//
// Behaviour
// - Read holds write strobe high with select and enable low; memory drives data.
// - Controller never drives the bus while memory outputs are on.
// - Address valid at write start and held stable through write end.
// - Write interval 12/13/15 ns with enable high, longer with enable low.
// - Write data valid 8/9/10 ns before write end; zero hold allowed.
// - Select and address lead write end 12/13/15 ns; cycle 17/20/25 ns.
`timescale 1ns/1ns
module asp_ctrl
	import asp_pkg::*;
#(
	parameter int GRADE = 2
) (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  nrst_in,
	// User request
	input  wire logic                  req_valid_in,
	input  wire logic                  req_write_in,
	input  wire logic [ASP_ADDR_W-1:0] req_addr_in,
	input  wire logic [ASP_DATA_W-1:0] req_wdata_in,
	output logic                       req_ready_out,
	// User answer
	output logic                       rsp_valid_out,
	output logic [ASP_DATA_W-1:0]      rsp_rdata_out,
	// Memory pins
	output logic [ASP_ADDR_W-1:0]      word_address_out,
	output logic                       sel_n_out,
	output logic                       wstrobe_n_out,
	output logic                       oen_n_out,
	input  wire logic [ASP_DATA_W-1:0] shared_data_bus_in,
	output logic [ASP_DATA_W-1:0]      shared_data_bus_out,
	output logic                       shared_data_bus_oe_out
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Larger of two cycle counts
	function automatic int max_of(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// True in the states that frame a write with select low
	function automatic logic frames_write(input asp_state_e s);
		return (s == ASP_WSET) || (s == ASP_WPULSE);
	endfunction

	// ------------------------------------------------------------
	// Phase lengths in clocks
	// ------------------------------------------------------------
	localparam int RC_CYC = asp_cycles_up(ASP_READ_CYCLE_MIN_NS[GRADE]);
	localparam int AA_CYC = asp_cycles_up(ASP_ADDRESS_TO_DATA_MAX_NS[GRADE]);
	localparam int CO_CYC = asp_cycles_up(ASP_SELECT_TO_DATA_MAX_NS[GRADE]);
	localparam int OE_CYC = asp_cycles_up(ASP_ENABLE_TO_DATA_MAX_NS[GRADE]);
	// Select, address and enable all move on one edge, so the slowest access decides
	localparam int RD_CYC = max_of(max_of(RC_CYC, AA_CYC), max_of(CO_CYC, OE_CYC));
	localparam int WP_CYC = asp_cycles_up(ASP_WRITE_PULSE_MIN_NS[GRADE]);
	localparam int DS_CYC = asp_cycles_up(ASP_DATA_SETUP_TO_WRITE_END_NS[GRADE]);
	localparam int CW_CYC = asp_cycles_up(ASP_SELECT_TO_WRITE_END_MIN_NS[GRADE]);
	localparam int WC_CYC = asp_cycles_up(ASP_WRITE_CYCLE_MIN_NS[GRADE]);
	localparam int PULSE0 = max_of(WP_CYC, DS_CYC);
	localparam int PULSE1 = max_of(PULSE0, CW_CYC);
	// Setup cycle plus pulse must also meet the whole write cycle
	localparam int PULSE  = (PULSE1 + 1 >= WC_CYC) ? PULSE1 : WC_CYC - 1;

	// Refuse grades and counts that the phase counter cannot time
	initial begin
		if (PULSE < WP_CYC || PULSE + 1 < WC_CYC) begin
			$error("asp_ctrl: write pulse shorter than the grade allows");
		end
		if (RD_CYC < OE_CYC || RD_CYC < RC_CYC) begin
			$error("asp_ctrl: read phase shorter than the grade allows");
		end
		if (GRADE < 0 || GRADE >= ASP_GRADES) begin
			$error("asp_ctrl: unsupported speed grade");
		end
		if (RD_CYC >= (1 << ASP_CNT_W) || PULSE >= (1 << ASP_CNT_W)) begin
			$error("asp_ctrl: phase counter too narrow");
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	asp_state_e state_q;
	asp_state_e state_d;
	logic                  cnt_load;
	logic [ASP_CNT_W-1:0]  cnt_value;
	logic                  cnt_done;

	asp_count #(
		.CNT_W (ASP_CNT_W)
	) u_count (
		.clk_in   (clk_in),
		.nrst_in  (nrst_in),
		.load_in  (cnt_load),
		.value_in (cnt_value),
		.done_out (cnt_done)
	);

	wire take = req_valid_in && req_ready_out;

	always_comb begin
		state_d   = state_q;
		cnt_load  = 1'b0;
		cnt_value = '0;
		case (state_q)
			ASP_IDLE: begin
				if (take && req_write_in) begin
					state_d = ASP_WSET;
				end else if (take) begin
					state_d   = ASP_RSEL;
					cnt_load  = 1'b1;
					cnt_value = ASP_CNT_W'(RD_CYC - 1);
				end
			end
			ASP_RSEL: begin
				if (cnt_done) begin
					state_d = ASP_RDONE;
				end
			end
			ASP_RDONE: begin
				state_d = ASP_IDLE;
			end
			ASP_WSET: begin
				state_d   = ASP_WPULSE;
				cnt_load  = 1'b1;
				cnt_value = ASP_CNT_W'(PULSE - 1);
			end
			ASP_WPULSE: begin
				if (cnt_done) begin
					state_d = ASP_WEND;
				end
			end
			ASP_WEND: begin
				state_d = ASP_IDLE;
			end
			default: begin
				state_d = ASP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= ASP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Address and data
	// ------------------------------------------------------------
	// Address only changes when a request is taken, so it is stable across the strobe
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			word_address_out    <= '0;
			shared_data_bus_out <= '0;
		end else if (take) begin
			word_address_out    <= req_addr_in;
			shared_data_bus_out <= req_wdata_in;
		end
	end

	// ------------------------------------------------------------
	// Strobes
	// ------------------------------------------------------------
	// Enable stays high for writes: shorter pulse allowed and the memory never drives
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sel_n_out     <= 1'b1;
			wstrobe_n_out <= 1'b1;
			oen_n_out     <= 1'b1;
		end else begin
			sel_n_out     <= !(state_d == ASP_RSEL || frames_write(state_d));
			wstrobe_n_out <= !(state_d == ASP_WPULSE);
			oen_n_out     <= !(state_d == ASP_RSEL);
		end
	end

	// Bus driven only while enable is high and a write is framed
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shared_data_bus_oe_out <= 1'b0;
		end else begin
			shared_data_bus_oe_out <= frames_write(state_d);
		end
	end

	// ------------------------------------------------------------
	// Handshake and answer
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
		end else begin
			// Ready drops on the take edge so a held request is not taken twice
			req_ready_out <= (state_d == ASP_IDLE) && !(state_q == ASP_IDLE && take);
			rsp_valid_out <= (state_q == ASP_RDONE) || (state_q == ASP_WEND);
			if (state_q == ASP_RSEL && cnt_done) begin
				// Taken on the edge that raises select and enable, while the memory still drives
				rsp_rdata_out <= shared_data_bus_in;
			end
		end
	end

endmodule

/* File: verif/asp_ctrl_chk.sv */
// Pin timing checker for the static memory port controller
`timescale 1ns/1ns
module asp_ctrl_chk
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic                  clk_in,
	input wire logic                  nrst_in,
	// Watched outputs
	input wire logic                  rsp_valid_out,
	input wire logic [ASP_ADDR_W-1:0] word_address_out,
	input wire logic                  sel_n_out,
	input wire logic                  wstrobe_n_out,
	input wire logic                  oen_n_out,
	input wire logic [ASP_DATA_W-1:0] shared_data_bus_out,
	input wire logic                  shared_data_bus_oe_out
);
	// Cycle figures hold for the default grade 2 only
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_no_contention: assert property (!(shared_data_bus_oe_out && !oen_n_out))
		else $error("bus driven during read");
	a_idle_quiet: assert property (sel_n_out |-> oen_n_out && !shared_data_bus_oe_out)
		else $error("pins active while deselected");
	a_read_pins: assert property (!oen_n_out |-> wstrobe_n_out && !sel_n_out)
		else $error("read without select or with strobe");
	a_read_length: assert property ($fell(oen_n_out) |-> !oen_n_out[*3] ##1 oen_n_out ##1 rsp_valid_out)
		else $error("read cycle length wrong");
	a_addr_held: assert property (!wstrobe_n_out |-> $stable(word_address_out) && !sel_n_out)
		else $error("address moved in write");
	a_data_setup: assert property (!wstrobe_n_out |-> shared_data_bus_oe_out && $stable(shared_data_bus_out))
		else $error("write data not settled");
	a_pulse_len: assert property ($fell(wstrobe_n_out) |-> !$past(sel_n_out) ##1 !wstrobe_n_out ##1 (wstrobe_n_out && sel_n_out))
		else $error("write pulse length wrong");
	a_write_cycle: assert property ($rose(shared_data_bus_oe_out) |-> (!sel_n_out && wstrobe_n_out) ##1 !wstrobe_n_out[*2] ##1 !shared_data_bus_oe_out ##1 rsp_valid_out)
		else $error("write cycle length wrong");
endmodule
bind asp_ctrl asp_ctrl_chk u_chk (.*);

/* File: verif/asp_mem_model.sv */
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/1ns
module asp_mem_model
	import asp_pkg::*;
#(
	parameter int ACC_NS = 25
) (
	// Memory pins
	input  wire logic [ASP_ADDR_W-1:0] word_address_in,
	input  wire logic                  sel_n_in,
	input  wire logic                  wstrobe_n_in,
	input  wire logic                  oen_n_in,
	input  wire logic [ASP_DATA_W-1:0] bus_in,
	output logic      [ASP_DATA_W-1:0] bus_out
);
	logic [ASP_DATA_W-1:0] mem [ASP_WORDS];
	logic [ASP_DATA_W-1:0] slow;
	logic                  drv;
	logic                  ready;
	assign drv = !sel_n_in && !oen_n_in && wstrobe_n_in;
	assign #ACC_NS slow = mem[word_address_in];
	assign #ACC_NS ready = drv;
	// Floating bus shows inverted data, so an early or late sample fails
	assign bus_out = (drv && ready) ? slow : ~mem[word_address_in];
	always @* begin
		if (!sel_n_in && !wstrobe_n_in) begin
			mem[word_address_in] = bus_in;
		end
	end
endmodule

/* File: verif/asp_ctrl_tb.sv */
// Self-checking bench of the static memory port controller with a memory model
`timescale 1ns/1ns
module asp_ctrl_tb;
	import asp_pkg::*;
	typedef struct {logic wr; logic [ASP_ADDR_W-1:0] a; logic [ASP_DATA_W-1:0] d, e;} asp_row_s;
	logic                  clk_in = 0, nrst_in = 0, req_valid_in = 0, req_write_in = 0;
	logic [ASP_ADDR_W-1:0] req_addr_in = '0, word_address_out;
	logic [ASP_DATA_W-1:0] req_wdata_in = '0, rsp_rdata_out, shared_data_bus_out, mdat;
	logic                  req_ready_out, rsp_valid_out, sel_n_out, wstrobe_n_out, oen_n_out;
	logic                  shared_data_bus_oe_out;
	wire  [ASP_DATA_W-1:0] shared_data_bus_in;
	int                    fails = 0, comparisons = 0;
	asp_row_s rows [8] = '{'{1, 19'h00000, 8'ha5, 8'h00}, '{1, 19'h7ffff, 8'h3c, 8'h00},
		'{0, 19'h00000, 8'h00, 8'ha5}, '{0, 19'h7ffff, 8'h00, 8'h3c},
		'{1, 19'h00000, 8'h5a, 8'h00}, '{0, 19'h00000, 8'h00, 8'h5a},
		'{1, 19'h2aaaa, 8'hff, 8'h00}, '{0, 19'h2aaaa, 8'h00, 8'hff}};
	always #5 clk_in = ~clk_in;
	// Wire delay keeps the zero-hold write end free of a same-step race in the model
	assign #1 shared_data_bus_in = shared_data_bus_oe_out ? shared_data_bus_out : mdat;
	asp_ctrl #(.GRADE(2)) u_dut (.*);
	asp_mem_model #(.ACC_NS(25)) u_mem (.word_address_in(word_address_out), .sel_n_in(sel_n_out),
		.wstrobe_n_in(wstrobe_n_out), .oen_n_in(oen_n_out), .bus_in(shared_data_bus_in), .bus_out(mdat));
	// --------------------------------------------------
	// Checks and bus tasks
	// --------------------------------------------------
	task automatic chkd(input logic [ASP_DATA_W-1:0] g, e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t data %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t pin %b expected %b", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_for(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 50) begin
			fails++;
			$display("[ERR] %0t handshake timeout", $time);
			give_verdict();
		end
	endtask
	// A busy flag also keeps a second request up for one cycle while the port is busy
	task automatic op(input asp_row_s r, input logic busy);
		wait_for(req_ready_out);
		@(posedge clk_in);
		req_valid_in <= 1;
		req_write_in <= r.wr;
		req_addr_in <= r.a;
		req_wdata_in <= r.d;
		@(posedge clk_in);
		req_valid_in <= busy;
		req_addr_in <= r.a ^ 19'h00001;
		req_wdata_in <= ~r.d;
		@(posedge clk_in);
		req_valid_in <= 0;
		wait_for(rsp_valid_out);
		if (!r.wr) chkd(rsp_rdata_out, r.e);
	endtask
	// --------------------------------------------------
	// Sequence
	// --------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_in);
		chkb(sel_n_out, 1'b1);
		chkb(shared_data_bus_oe_out, 1'b0);
		nrst_in <= 1;
		$display("test reset done");
		foreach (rows[i]) op(rows[i], 1'b0);
		$display("test table done");
		op('{1, 19'h00101, 8'h11, 8'h00}, 1'b0);
		op('{1, 19'h00100, 8'h77, 8'h00}, 1'b1);
		op('{0, 19'h00101, 8'h00, 8'h11}, 1'b0);
		op('{0, 19'h00100, 8'h00, 8'h77}, 1'b0);
		$display("test busy refusal done");
		wait_for(req_ready_out);
		@(posedge clk_in);
		req_valid_in <= 1;
		req_write_in <= 1;
		@(posedge clk_in);
		req_valid_in <= 0;
		@(posedge clk_in);
		nrst_in <= 0;
		@(negedge clk_in);
		chkb(wstrobe_n_out, 1'b1);
		chkb(shared_data_bus_oe_out, 1'b0);
		@(posedge clk_in);
		nrst_in <= 1;
		op('{0, 19'h00000, 8'h00, 8'h5a}, 1'b0);
		$display("test reset mid write done");
		give_verdict();
	end
endmodule
